// *** hw/smbcfg_defs.vh ***
/*
 * Constants of the SMBus configuration and timeout block: register
 * indices, field positions, reset values and timing counts.
 * Assumes it is included once per file by its bare name.
 */
`ifndef SMBCFG_DEFS_VH
`define SMBCFG_DEFS_VH

// Register indices; byte address is four times the index
`define SC_IDX_CFG 10'h0c1
`define SC_IDX_IRQ_STAT 10'h0c4
`define SC_IDX_IRQ_EN 10'h0c5
`define SC_IDX_IRQ_CLR 10'h0c6
`define SC_IDX_LINE 10'h0c7
`define SC_ADDR_W 12

// Configuration register fields
`define SC_B_ENABLE 7
`define SC_B_INHIBIT 6
`define SC_B_BUSY 5
`define SC_B_HOLD 4
`define SC_B_TOE 3
`define SC_B_FTE 2
`define SC_B_CS_HI 1
`define SC_B_CS_LO 0
`define SC_CFG_RESET 8'h00
`define SC_CFG_WMASK 8'hdf

// Line register fields
`define SC_LN_SCL 0
`define SC_LN_SDA 1
`define SC_LN_BUSY 2
`define SC_LN_INH 3

// Event status fields
`define SC_EV_W 3
`define SC_EV_START 0
`define SC_EV_STOP 1
`define SC_EV_FREE 2
`define SC_EV_RESET 3'h0

// Clock source codes
`define SC_CS_T0 2'h0
`define SC_CS_T1 2'h1
`define SC_CS_T2H 2'h2
`define SC_CS_T2L 2'h3

// Timing in system clocks and source periods
`define SC_FREE_TICKS 4'ha
`define SC_CNT_W 4
`define SC_SETUP_NORM 4'h1
`define SC_HOLD_NORM 4'h3
`define SC_SETUP_EXT 4'hb
`define SC_HOLD_EXT 4'hc

// Bus answers and idle pin level
`define SC_RESP_OKAY 2'h0
`define SC_RESP_SLVERR 2'h2
`define SC_PIN_IDLE 1'b1

`endif

// *** hw/smbcfg_free_timer.v ***
/*
 * Bus-free timeout: counts selected clock-source ticks while both
 * lines stay high and fires once after more than ten of them.
 * Assumes idle and tick are on clk_sys; tick is a one-cycle pulse.
 */
`timescale 1ns/1ps
`include "smbcfg_defs.vh"

module smbcfg_free_timer (
   input wire clk_sys,
   input wire rst,
   input wire ce,
   input wire arm,
   input wire idle,
   input wire tick,
   output reg fire_q
);

   reg [`SC_CNT_W-1:0] cnt_q;
   reg done_q;

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt_q <= {`SC_CNT_W{1'b0}};
         done_q <= 1'b0;
         fire_q <= 1'b0;
      end else if (ce) begin
         fire_q <= 1'b0;
         if (!arm || !idle) begin
            cnt_q <= {`SC_CNT_W{1'b0}};
            done_q <= 1'b0;
         end else if (tick && !done_q) begin
            // Eleventh tick means more than ten periods high
            if (cnt_q == `SC_FREE_TICKS) begin
               fire_q <= 1'b1;
               done_q <= 1'b1;
            end else begin
               cnt_q <= cnt_q + 1'b1;
            end
         end
      end
   end

endmodule

// *** hw/smbcfg_sync.v ***
/*
 * Two flip-flop synchroniser for the SCL and SDA pin levels.
 * Assumes the pins idle high and are asynchronous to clk_sys.
 */
`timescale 1ns/1ps
`include "smbcfg_defs.vh"

module smbcfg_sync (
   input wire clk_sys,
   input wire rst,
   input wire ce,
   input wire pin_in,
   output wire pin_sync
);

   reg meta_q;
   reg sync_q;

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         meta_q <= `SC_PIN_IDLE;
         sync_q <= `SC_PIN_IDLE;
      end else if (ce) begin
         meta_q <= pin_in;
         sync_q <= meta_q;
      end
   end

   assign pin_sync = sync_q;

endmodule

// *** hw/smbcfg_top.v ***
/*
 * SMBus configuration and timeout block with an AXI4-Lite register
 * slave: enable, slave inhibit, busy flag, hold extension, SCL-low
 * timer control, bus-free timeout and clock-source selection.
 * Assumes SCL and SDA pin levels arrive asynchronously, timer
 * overflows are one-cycle pulses on clk_sys, and the bus master
 * keeps one read and one write outstanding at most.
 */
// Chosen here: the AXI4-Lite slave port.

// Notes on behaviour
// - Enable bit switches interface and line monitoring
// - Busy set during transfer, cleared by stop/free
// - Hold-extension bit selects extended setup/hold times
// - Bus free after over ten source periods high
// - Two-bit field picks timer overflow timing base
// - Codes map timer 0, 1, 2 high, 2 low
// - Inhibit NACKs addresses from next start onward
// - Companion timer reloads on SCL high, counts low
// - Free timeout acts as stop with interrupt
`timescale 1ns/1ps
`include "smbcfg_defs.vh"

module smbcfg_top (
   input wire clk_sys,
   input wire rst,
   input wire ce,
   input wire scl_in,
   input wire sda_in,
   input wire t0_ovf,
   input wire t1_ovf,
   input wire t2h_ovf,
   input wire t2l_ovf,
   input wire [`SC_ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [`SC_ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg src_tick_q,
   output reg timer_reload_q,
   output reg timer_count_q,
   output reg [`SC_CNT_W-1:0] sda_setup_min_q,
   output reg [`SC_CNT_W-1:0] sda_hold_min_q,
   output reg slave_nack_q,
   output reg stop_indication_q,
   output reg irq_q
);

   // Register decode, used by both the read and the write path
   function [4:0] sc_decode;
      input [`SC_ADDR_W-1:0] addr;
      begin
         sc_decode = 5'h00;
         case (addr[`SC_ADDR_W-1:2])
            `SC_IDX_CFG: sc_decode = 5'h01;
            `SC_IDX_IRQ_STAT: sc_decode = 5'h02;
            `SC_IDX_IRQ_EN: sc_decode = 5'h04;
            `SC_IDX_IRQ_CLR: sc_decode = 5'h08;
            `SC_IDX_LINE: sc_decode = 5'h10;
            default: sc_decode = 5'h00;
         endcase
      end
   endfunction

   wire scl_s;
   wire sda_s;
   wire free_fire;
   reg scl_prev_q;
   reg sda_prev_q;
   reg [7:0] cfg_q;
   reg busy_q;
   reg inhibit_act_q;
   reg [`SC_EV_W-1:0] ev_stat_q;
   reg [`SC_EV_W-1:0] ev_en_q;
   reg [`SC_ADDR_W-1:0] aw_addr_q;
   reg aw_held_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   reg w_held_q;
   reg src_sel_d;

   // Live views of the configuration fields
   wire enable = cfg_q[`SC_B_ENABLE];
   wire toe_on = enable && cfg_q[`SC_B_TOE];
   wire fte_on = enable && cfg_q[`SC_B_FTE];
   wire [1:0] cs_sel = {cfg_q[`SC_B_CS_HI], cfg_q[`SC_B_CS_LO]};
   wire [4:0] wsel = sc_decode(aw_addr_q);
   wire [4:0] rsel = sc_decode(s_axi_araddr);
   wire do_write = aw_held_q && w_held_q && !s_axi_bvalid;
   // Register writes act only through byte lane 0
   wire wr_cfg = do_write && wsel[0] && w_strb_q[0];
   wire wr_en = do_write && wsel[2] && w_strb_q[0];
   wire wr_clr = do_write && wsel[3] && w_strb_q[0];

   // Line conditions while monitoring
   wire start_det = enable && scl_s && scl_prev_q &&
      sda_prev_q && !sda_s;
   wire stop_det = enable && scl_s && scl_prev_q &&
      !sda_prev_q && sda_s;
   wire [`SC_EV_W-1:0] ev_set = {free_fire, stop_det, start_det};

   smbcfg_sync u_scl_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .pin_in(scl_in),
      .pin_sync(scl_s)
   );

   smbcfg_sync u_sda_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .pin_in(sda_in),
      .pin_sync(sda_s)
   );

   smbcfg_free_timer u_free (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .arm(fte_on),
      .idle(scl_s && sda_s),
      .tick(src_tick_q),
      .fire_q(free_fire)
   );

   // Clock source selection
   always @* begin
      case (cs_sel)
         `SC_CS_T0: src_sel_d = t0_ovf;
         `SC_CS_T1: src_sel_d = t1_ovf;
         `SC_CS_T2H: src_sel_d = t2h_ovf;
         `SC_CS_T2L: src_sel_d = t2l_ovf;
         default: src_sel_d = 1'b0;
      endcase
   end

   // Line history, configuration and line-driven state
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         scl_prev_q <= `SC_PIN_IDLE;
         sda_prev_q <= `SC_PIN_IDLE;
         cfg_q <= `SC_CFG_RESET;
         busy_q <= 1'b0;
         inhibit_act_q <= 1'b0;
         src_tick_q <= 1'b0;
         timer_reload_q <= 1'b0;
         timer_count_q <= 1'b0;
         sda_setup_min_q <= `SC_SETUP_NORM;
         sda_hold_min_q <= `SC_HOLD_NORM;
         slave_nack_q <= 1'b0;
      end else if (ce) begin
         scl_prev_q <= scl_s;
         sda_prev_q <= sda_s;
         if (wr_cfg) begin
            cfg_q <= w_data_q[7:0] & `SC_CFG_WMASK;
         end
         src_tick_q <= src_sel_d;
         // Busy: set at start, cleared at stop or free timeout
         if (!enable || stop_det || free_fire) begin
            busy_q <= 1'b0;
         end else if (start_det) begin
            busy_q <= 1'b1;
         end
         // Inhibit takes hold only at a start
         if (!enable) begin
            inhibit_act_q <= 1'b0;
         end else if (start_det) begin
            inhibit_act_q <= cfg_q[`SC_B_INHIBIT];
         end
         slave_nack_q <= enable && inhibit_act_q;
         // Companion timer control for the SCL-low timeout
         timer_reload_q <= toe_on && scl_s;
         timer_count_q <= toe_on && !scl_s;
         if (cfg_q[`SC_B_HOLD]) begin
            sda_setup_min_q <= `SC_SETUP_EXT;
            sda_hold_min_q <= `SC_HOLD_EXT;
         end else begin
            sda_setup_min_q <= `SC_SETUP_NORM;
            sda_hold_min_q <= `SC_HOLD_NORM;
         end
      end
   end

   // Sticky events, enable mask and interrupt; set beats clear
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ev_stat_q <= `SC_EV_RESET;
         ev_en_q <= `SC_EV_RESET;
         stop_indication_q <= 1'b0;
         irq_q <= 1'b0;
      end else if (ce) begin
         if (wr_en) begin
            ev_en_q <= w_data_q[`SC_EV_W-1:0];
         end
         if (wr_clr) begin
            ev_stat_q <= (ev_stat_q & ~w_data_q[`SC_EV_W-1:0]) | ev_set;
         end else begin
            ev_stat_q <= ev_stat_q | ev_set;
         end
         // Free timeout raises the stop indication like a stop
         if (stop_det || free_fire) begin
            stop_indication_q <= 1'b1;
         end else if (wr_clr && w_data_q[`SC_EV_STOP]) begin
            stop_indication_q <= 1'b0;
         end
         irq_q <= |(ev_stat_q & ev_en_q);
      end
   end

   // Write channel: address and data taken in either order
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         aw_addr_q <= {`SC_ADDR_W{1'b0}};
         aw_held_q <= 1'b0;
         w_data_q <= 32'h0;
         w_strb_q <= 4'h0;
         w_held_q <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SC_RESP_OKAY;
      end else if (ce) begin
         s_axi_awready <= !aw_held_q && !s_axi_awready &&
            s_axi_awvalid && !s_axi_bvalid;
         s_axi_wready <= !w_held_q && !s_axi_wready &&
            s_axi_wvalid && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_q <= s_axi_awaddr;
            aw_held_q <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            w_held_q <= 1'b1;
         end
         if (do_write) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wsel == 5'h00 || wsel[1] || wsel[4]) ?
               `SC_RESP_SLVERR : `SC_RESP_OKAY;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read channel
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `SC_RESP_OKAY;
      end else if (ce) begin
         s_axi_arready <= !s_axi_arready && s_axi_arvalid &&
            !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= (rsel == 5'h00 || rsel[3]) ?
               `SC_RESP_SLVERR : `SC_RESP_OKAY;
            s_axi_rdata <= 32'h0;
            if (rsel[0]) begin
               s_axi_rdata[7:0] <= cfg_q;
               // Busy reads live, not from the stored bit
               s_axi_rdata[`SC_B_BUSY] <= busy_q;
            end
            if (rsel[1]) begin
               s_axi_rdata[`SC_EV_W-1:0] <= ev_stat_q;
            end
            if (rsel[2]) begin
               s_axi_rdata[`SC_EV_W-1:0] <= ev_en_q;
            end
            // Line register: synced pins, busy and inhibit state
            if (rsel[4]) begin
               s_axi_rdata[`SC_LN_SCL] <= scl_s;
               s_axi_rdata[`SC_LN_SDA] <= sda_s;
               s_axi_rdata[`SC_LN_BUSY] <= busy_q;
               s_axi_rdata[`SC_LN_INH] <= inhibit_act_q;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule

// *** test/smbcfg_peer.sv ***
/* Other SMBus devices: drive SCL and SDA through tasks.
   Assumes pull-ups, so released lines read high. */
`timescale 1ns/1ps
module smbcfg_peer (
   output reg scl,
   output reg sda
);
   localparam int H = 40;
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   // Start: SDA falls while SCL high
   task start_c;
      begin
         #3 sda = 1'b0;
         #H scl = 1'b0;
      end
   endtask
   // One bit, 80 ns clock period; SCL then stands low
   task bit_c(input b);
      begin
         sda = b;
         #H scl = 1'b1;
         #H scl = 1'b0;
      end
   endtask
   // Stop: SDA rises while SCL high
   task stop_c;
      begin
         sda = 1'b0;
         #H scl = 1'b1;
         #H sda = 1'b1;
         #H;
      end
   endtask
   // Release both lines without a stop
   task drop_c;
      begin
         sda = 1'b1;
         #H scl = 1'b1;
      end
   endtask
endmodule

// *** test/smbcfg_properties.sv ***
/* Checker on the ports of smbcfg_top.
   Assumes ce stays high; bound by port name below. */
`timescale 1ns/1ps
`include "smbcfg_defs.vh"
module smbcfg_props (
   input wire clk_sys,
   input wire rst,
   input wire scl_in,
   input wire t0_ovf,
   input wire t1_ovf,
   input wire t2h_ovf,
   input wire t2l_ovf,
   input wire s_axi_awready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire src_tick_q,
   input wire timer_reload_q,
   input wire timer_count_q,
   input wire [`SC_CNT_W-1:0] sda_setup_min_q,
   input wire [`SC_CNT_W-1:0] sda_hold_min_q,
   input wire slave_nack_q,
   input wire stop_indication_q,
   input wire irq_q
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_hold_pair: assert property (
      (sda_setup_min_q == `SC_SETUP_NORM && sda_hold_min_q == `SC_HOLD_NORM)
      || (sda_setup_min_q == `SC_SETUP_EXT && sda_hold_min_q == `SC_HOLD_EXT))
      else $error("setup and hold pair off");
   a_timer_excl: assert property (!(timer_reload_q && timer_count_q))
      else $error("reload and count together");
   a_count_scl: assert property (timer_count_q |->
      !$past(scl_in, 3))
      else $error("count while scl high");
   a_reload_scl: assert property (timer_reload_q |->
      $past(scl_in, 3))
      else $error("reload while scl low");
   a_src_tick: assert property (src_tick_q |->
      $past(t0_ovf || t1_ovf || t2h_ovf || t2l_ovf))
      else $error("tick without overflow");
   a_aw_single: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("awready longer than a cycle");
   a_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("bvalid stays after handshake");
   a_r_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("rvalid stays after handshake");
   a_reset_zero: assert property ($past(rst) |-> !irq_q &&
      !stop_indication_q && !slave_nack_q && !timer_reload_q)
      else $error("outputs not clear after reset");
endmodule
bind smbcfg_top smbcfg_props u_props (
   .clk_sys(clk_sys),
   .rst(rst),
   .scl_in(scl_in),
   .t0_ovf(t0_ovf),
   .t1_ovf(t1_ovf),
   .t2h_ovf(t2h_ovf),
   .t2l_ovf(t2l_ovf),
   .s_axi_awready(s_axi_awready),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready),
   .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready),
   .src_tick_q(src_tick_q),
   .timer_reload_q(timer_reload_q),
   .timer_count_q(timer_count_q),
   .sda_setup_min_q(sda_setup_min_q),
   .sda_hold_min_q(sda_hold_min_q),
   .slave_nack_q(slave_nack_q),
   .stop_indication_q(stop_indication_q),
   .irq_q(irq_q)
);

// *** test/tb_smbus_config_timeout.sv ***
/* Self-checking bench for smbcfg_top.
   Assumes the peer model and the bound checker. */
`timescale 1ns/1ps
`include "smbcfg_defs.vh"
module tb_smbus_config_timeout;
   localparam [11:0] A_CFG = {`SC_IDX_CFG, 2'b00};
   localparam [11:0] A_ST = {`SC_IDX_IRQ_STAT, 2'b00};
   localparam [11:0] A_EN = {`SC_IDX_IRQ_EN, 2'b00};
   localparam [11:0] A_CLR = {`SC_IDX_IRQ_CLR, 2'b00};
   localparam int TO_CYC = 20;
   reg clk_sys = 1'b0;
   reg rst = 1'b1;
   reg ce = 1'b1;
   reg [3:0] ovf = 4'h0;
   reg [11:0] awaddr = 12'h0, araddr = 12'h0;
   reg [31:0] wdata = 32'h0;
   reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   wire awready, wready, bvalid, arready, rvalid, scl, sda;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire src_tick, reload, count, nack, stop_ind, irq;
   wire [3:0] su, ho;
   integer err_count = 0, tests_run = 0, i, j;
   reg [7:0] v;
   reg [31:0] d;
   reg [1:0] r;
   always #5 clk_sys = ~clk_sys;
   smbcfg_peer u_peer (.scl(scl), .sda(sda));
   smbcfg_top i_dut (.clk_sys(clk_sys), .rst(rst), .ce(ce),
      .scl_in(scl), .sda_in(sda), .t0_ovf(ovf[0]), .t1_ovf(ovf[1]),
      .t2h_ovf(ovf[2]), .t2l_ovf(ovf[3]), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .src_tick_q(src_tick),
      .timer_reload_q(reload), .timer_count_q(count),
      .sda_setup_min_q(su), .sda_hold_min_q(ho), .slave_nack_q(nack),
      .stop_indication_q(stop_ind), .irq_q(irq));
   function [7:0] cfg_exp(input [7:0] w, input busy);
      cfg_exp = (w & `SC_CFG_WMASK) | {2'b00, busy, 5'h00};
   endfunction
   function [3:0] setup_exp(input ext);
      setup_exp = ext ? `SC_SETUP_EXT : `SC_SETUP_NORM;
   endfunction
   function [3:0] hold_exp(input ext);
      hold_exp = ext ? `SC_HOLD_EXT : `SC_HOLD_NORM;
   endfunction
   task chk(input [31:0] g, input [31:0] e);
      begin
         tests_run = tests_run + 1;
         if (g !== e) begin
            err_count = err_count + 1;
            $display("unexpected %0t got %h exp %h", $time, g, e);
         end
      end
   endtask
   task wr(input [11:0] a, input [7:0] dv, output [1:0] rr);
      reg ta, tw, tb;
      begin
         @(posedge clk_sys);
         awaddr <= a;
         wdata <= {24'h0, dv};
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         tb = 1'b0;
         while (!tb) begin
            @(negedge clk_sys);
            ta = awready;
            tw = wready;
            tb = bvalid;
            rr = bresp;
            @(posedge clk_sys);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
         end
         @(negedge clk_sys);
      end
   endtask
   task rd(input [11:0] a, output [31:0] dv, output [1:0] rr);
      reg ta, tv;
      begin
         @(posedge clk_sys);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         tv = 1'b0;
         while (!tv) begin
            @(negedge clk_sys);
            ta = arready;
            tv = rvalid;
            dv = rdata;
            rr = rresp;
            @(posedge clk_sys);
            if (ta) arvalid <= 1'b0;
            if (tv) rready <= 1'b0;
         end
         @(negedge clk_sys);
      end
   endtask
   task final_report;
      begin
         if (err_count == 0 && tests_run > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   initial begin
      #100000;
      err_count = err_count + 1;
      final_report;
   end
   initial begin
      void'($urandom(32'ha3a7));
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      rd(A_CFG, d, r);
      chk(d, 32'h0);
      for (i = 0; i < 8; i = i + 1) begin
         d = $urandom;
         v = (i == 0) ? 8'hff : d[7:0];
         wr(A_CFG, v, r);
         chk(r, `SC_RESP_OKAY);
         rd(A_CFG, d, r);
         chk(d, cfg_exp(v, 1'b0));
         chk(su, setup_exp(v[4]));
         chk(ho, hold_exp(v[4]));
         chk(reload, v[7] & v[3]);
      end
      wr(12'h000, 8'h11, r);
      chk(r, `SC_RESP_SLVERR);
      rd(A_CLR, d, r);
      chk(r, `SC_RESP_SLVERR);
      for (i = 0; i < 4; i = i + 1) begin
         wr(A_CFG, i[7:0], r);
         for (j = 0; j < 4; j = j + 1) begin
            @(posedge clk_sys);
            ovf <= 4'h1 << j;
            @(posedge clk_sys);
            ovf <= 4'h0;
            @(negedge clk_sys);
            chk(src_tick, i == j);
         end
      end
      // Clock enable low freezes the source tick
      @(posedge clk_sys);
      ce <= 1'b0;
      ovf <= 4'hf;
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk(src_tick, 1'b0);
      @(posedge clk_sys);
      ce <= 1'b1;
      ovf <= 4'h0;
      // Frame ended by a stop, interrupt masked and cleared
      wr(A_EN, 8'h06, r);
      wr(A_CFG, 8'h8c, r);
      u_peer.start_c;
      rd(A_CFG, d, r);
      chk(d[5], 1'b1);
      chk(count, 1'b1);
      chk(nack, 1'b0);
      d = $urandom;
      u_peer.bit_c(d[0]);
      u_peer.stop_c;
      rd(A_CFG, d, r);
      chk(d[5], 1'b0);
      chk(stop_ind, 1'b1);
      chk(irq, 1'b1);
      wr(A_EN, 8'h00, r);
      rd(A_ST, d, r);
      chk(d, 32'h3);
      chk(irq, 1'b0);
      wr(A_CLR, 8'h07, r);
      wr(A_EN, 8'h06, r);
      rd(A_ST, d, r);
      chk(d, 32'h0);
      chk({irq, stop_ind}, 2'b00);
      // Inhibit, then bus left high without a stop
      wr(A_CFG, 8'hc4, r);
      u_peer.start_c;
      rd(A_CFG, d, r);
      chk(nack, 1'b1);
      u_peer.drop_c;
      for (j = 0; j < 11; j = j + 1) begin
         @(posedge clk_sys);
         ovf <= 4'h1;
         @(posedge clk_sys);
         ovf <= 4'h0;
         if (j == 9) begin
            rd(A_CFG, d, r);
            chk({d[5], stop_ind}, 2'b10);
         end
      end
      rd(A_CFG, d, r);
      chk(d[5], 1'b0);
      rd(A_ST, d, r);
      chk(d[2], 1'b1);
      chk({stop_ind, irq}, 2'b11);
      // Disabled interface ignores a start
      wr(A_CLR, 8'h07, r);
      wr(A_CFG, 8'h04, r);
      u_peer.start_c;
      rd(A_CFG, d, r);
      chk(d[5], 1'b0);
      rd(A_ST, d, r);
      chk(d, 32'h0);
      u_peer.stop_c;
      // SCL held low; a short bench timer stands in for software's
      wr(A_CFG, 8'h88, r);
      u_peer.start_c;
      repeat (TO_CYC) @(negedge clk_sys);
      chk({count, reload}, 2'b10);
      wr(A_CFG, 8'h08, r);
      wr(A_CFG, 8'h88, r);
      rd(A_CFG, d, r);
      chk(d, 32'h88);
      chk(count, 1'b1);
      u_peer.stop_c;
      final_report;
   end
endmodule
